// File: bps_pkg.sv
// shared constants for the bridge parity status block
package bps_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int          BPS_ADDR_W   = 8;
  localparam logic [1:0]  BPS_RESP_OK  = 2'h0;
  localparam logic [1:0]  BPS_RESP_ERR = 2'h2;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  BPS_OFF_PCMD  = 8'h04;
  localparam logic [7:0]  BPS_OFF_SSTAT = 8'h1c;
  localparam logic [7:0]  BPS_OFF_BCTL  = 8'h3c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          BPS_BIT_PERR_RESP  = 6;
  localparam int          BPS_BIT_MDPE       = 24;
  localparam int          BPS_BIT_DPE        = 31;
  localparam int          BPS_BIT_SPERR_RESP = 16;

  // index of each sticky bit in the status vector
  localparam int          BPS_STS_PDET = 0;
  localparam int          BPS_STS_PMST = 1;
  localparam int          BPS_STS_SDET = 2;
  localparam int          BPS_STS_SMST = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic        BPS_RST_RESP    = 1'b0;
  localparam logic [3:0]  BPS_RST_STS     = 4'h0;
  localparam logic        BPS_RST_PIN_N   = 1'b1;

  // ----------------------------------------------------------------
  // transaction types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BPS_TXN_READ    = 2'b00,
    BPS_TXN_POSTED  = 2'b01,
    BPS_TXN_DELAYED = 2'b10,
    BPS_TXN_NONE    = 2'b11
  } bps_txn_t;

endpackage

// File: bps_pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none

module bps_pin_sync #(
  parameter int          WIDTH   = 2,
  parameter logic        RST_VAL = 1'b1
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [WIDTH-1:0]  pin_in,
  output logic      [WIDTH-1:0]  level
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ----------------------------------------------------------------
  // per-bit chain; meta feeds only stage2
  // ----------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        meta[i]   <= RST_VAL;
        stage2[i] <= RST_VAL;
        stage3[i] <= RST_VAL;
        level[i]  <= RST_VAL;
      end else begin
        meta[i]   <= pin_in[i];
        stage2[i] <= meta[i];
        stage3[i] <= stage2[i];
        // a change counts only once two stages agree
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: bps_parity_status.sv
// parity status bits of a two-sided bridge, with an axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - a data parity error the bridge sees on the primary bus sets the primary detected bit, whatever the enables.
// - primary detected is set only for upstream reads and downstream posted or delayed writes.
// - a data parity error the bridge sees on the secondary bus sets the secondary detected bit, whatever the enables.
// - secondary detected is set only for downstream reads and upstream posted or delayed writes.
// - primary master parity bit is set only while the bridge masters the primary bus.
// - primary master parity bit is set only while the primary response enable is on.
// - primary master parity bit is triggered by the target's error pin or by the bridge's own check.
// - primary master parity bit covers upstream reads and writes only, never downstream.
// - secondary master parity bit is set only while the bridge masters the secondary bus.
// - secondary master parity bit is set only while the secondary response enable is on.
// - secondary master parity bit is triggered by the target's error pin or by the bridge's own check.
// - secondary master parity bit covers downstream reads and writes only, never upstream.
// - the secondary response enable sits in the bridge control register at offset 3ch.

module bps_parity_status (
  input  wire logic                           clk_sys,
  input  wire logic                           rst,
  // axi4-lite slave
  input  wire logic [bps_pkg::BPS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [bps_pkg::BPS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  // transaction context from the bridge core
  input  wire bps_pkg::bps_txn_t              txn_type,
  input  wire logic                           txn_upstream,
  input  wire logic                           master_pri,
  input  wire logic                           master_sec,
  input  wire logic                           perr_det_pri,
  input  wire logic                           perr_det_sec,
  // target-driven error pins
  input  wire logic                           primary_parity_err_n,
  input  wire logic                           secondary_parity_err_n,
  // state seen by the rest of the bridge
  output logic                                perr_resp_pri,
  output logic                                perr_resp_sec,
  output logic                                primary_det_err,
  output logic                                primary_master_err,
  output logic                                secondary_det_err,
  output logic                                secondary_master_err
);
  import bps_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                  aw_held;
  logic                  w_held;
  logic [BPS_ADDR_W-1:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic [3:0]            sts;
  logic [3:0]            next_sts;
  logic [1:0]            perr_n_filt;
  logic [1:0]            perr_n_prev;

  // ----------------------------------------------------------------
  // error pin input stage
  // ----------------------------------------------------------------
  bps_pin_sync #(
    .WIDTH   (2),
    .RST_VAL (BPS_RST_PIN_N)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  ({secondary_parity_err_n, primary_parity_err_n}),
    .level   (perr_n_filt)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      perr_n_prev <= {2{BPS_RST_PIN_N}};
    end else begin
      perr_n_prev <= perr_n_filt;
    end
  end

  // one-cycle event on each new assertion of a pin
  wire pin_evt_pri = !perr_n_filt[0] && perr_n_prev[0];
  wire pin_evt_sec = !perr_n_filt[1] && perr_n_prev[1];

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;

  wire aw_hs    = s_axi_awvalid && s_axi_awready;
  wire w_hs     = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_hs) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (w_hs) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  wire wr_pcmd  = do_write && (aw_addr[7:2] == BPS_OFF_PCMD[7:2]);
  wire wr_sstat = do_write && (aw_addr[7:2] == BPS_OFF_SSTAT[7:2]);
  wire wr_bctl  = do_write && (aw_addr[7:2] == BPS_OFF_BCTL[7:2]);
  wire wr_hit   = wr_pcmd || wr_sstat || wr_bctl;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= BPS_RESP_OK;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? BPS_RESP_OK : BPS_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // response enables
  // ----------------------------------------------------------------
  wire ld_resp_pri = wr_pcmd && w_strb[0];
  wire ld_resp_sec = wr_bctl && w_strb[2];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      perr_resp_pri <= BPS_RST_RESP;
      perr_resp_sec <= BPS_RST_RESP;
    end else begin
      if (ld_resp_pri) begin
        perr_resp_pri <= w_data[BPS_BIT_PERR_RESP];
      end
      if (ld_resp_sec) begin
        perr_resp_sec <= w_data[BPS_BIT_SPERR_RESP];
      end
    end
  end

  // ----------------------------------------------------------------
  // status set conditions
  // ----------------------------------------------------------------
  wire is_read  = (txn_type == BPS_TXN_READ);
  wire is_write = (txn_type == BPS_TXN_POSTED) || (txn_type == BPS_TXN_DELAYED);
  wire is_txn   = is_read || is_write;

  wire set_p_det = perr_det_pri
                 && ((is_read && txn_upstream) || (is_write && !txn_upstream));

  wire set_s_det = perr_det_sec
                 && ((is_read && !txn_upstream) || (is_write && txn_upstream));

  // pin or own check on primary
  wire p_mst_cause = pin_evt_pri || perr_det_pri;
  // bridge masters primary; enable; upstream only
  wire set_p_mst   = master_pri && perr_resp_pri && p_mst_cause
                   && is_txn && txn_upstream;

  // pin or own check on secondary
  wire s_mst_cause = pin_evt_sec || perr_det_sec;
  // bridge masters secondary; enable; downstream only
  wire set_s_mst   = master_sec && perr_resp_sec && s_mst_cause
                   && is_txn && !txn_upstream;

  wire [3:0] set_vec = {set_s_mst, set_s_det, set_p_mst, set_p_det};

  // ----------------------------------------------------------------
  // write-one-to-clear
  // ----------------------------------------------------------------
  wire clr_pri = wr_pcmd && w_strb[3];
  wire clr_sec = wr_sstat && w_strb[3];

  wire [3:0] clr_vec = {clr_sec && w_data[BPS_BIT_MDPE],
                        clr_sec && w_data[BPS_BIT_DPE],
                        clr_pri && w_data[BPS_BIT_MDPE],
                        clr_pri && w_data[BPS_BIT_DPE]};

  // sticky, set beats a same-cycle clear
  assign next_sts = set_vec | (sts & ~clr_vec);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sts <= BPS_RST_STS;
    end else begin
      sts <= next_sts;
    end
  end

  assign primary_det_err      = sts[BPS_STS_PDET];
  assign primary_master_err   = sts[BPS_STS_PMST];
  assign secondary_det_err    = sts[BPS_STS_SDET];
  assign secondary_master_err = sts[BPS_STS_SMST];

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  wire ar_hs   = s_axi_arvalid && s_axi_arready;
  wire rd_pcmd = (s_axi_araddr[7:2] == BPS_OFF_PCMD[7:2]);
  wire rd_ssts = (s_axi_araddr[7:2] == BPS_OFF_SSTAT[7:2]);
  wire rd_bctl = (s_axi_araddr[7:2] == BPS_OFF_BCTL[7:2]);

  wire [31:0] pcmd_word = (32'(perr_resp_pri) << BPS_BIT_PERR_RESP)
                        | (32'(sts[BPS_STS_PMST]) << BPS_BIT_MDPE)
                        | (32'(sts[BPS_STS_PDET]) << BPS_BIT_DPE);
  wire [31:0] ssts_word = (32'(sts[BPS_STS_SMST]) << BPS_BIT_MDPE)
                        | (32'(sts[BPS_STS_SDET]) << BPS_BIT_DPE);
  // enable read back from bridge control
  wire [31:0] bctl_word = 32'(perr_resp_sec) << BPS_BIT_SPERR_RESP;

  // unmapped words read as zero with an error response
  wire [31:0] rd_word = rd_pcmd ? pcmd_word :
                        rd_ssts ? ssts_word :
                        rd_bctl ? bctl_word : 32'h0000_0000;
  wire        rd_hit  = rd_pcmd || rd_ssts || rd_bctl;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= BPS_RESP_OK;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? BPS_RESP_OK : BPS_RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_pri_own_err;
    perr_det_pri && ((is_read && txn_upstream) || (is_write && !txn_upstream));
  endsequence

  sequence s_sec_own_err;
    perr_det_sec && ((is_read && !txn_upstream) || (is_write && txn_upstream));
  endsequence

  sequence s_bctl_read;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:2] == BPS_OFF_BCTL[7:2]);
  endsequence

  a_pdet_sets: assert property (
    s_pri_own_err |=> primary_det_err
  ) else $error("primary detected bit missed an own error");

  a_pdet_cause: assert property (
    $rose(primary_det_err) |-> $past(perr_det_pri && (is_read == txn_upstream) && is_txn)
  ) else $error("primary detected bit rose without a qualifying error");

  a_sdet_sets: assert property (
    s_sec_own_err |=> secondary_det_err
  ) else $error("secondary detected bit missed an own error");

  a_sdet_cause: assert property (
    $rose(secondary_det_err) |-> $past(perr_det_sec && (is_read != txn_upstream) && is_txn)
  ) else $error("secondary detected bit rose without a qualifying error");

  a_pmst_master: assert property (
    $rose(primary_master_err) |-> $past(master_pri) && $past(txn_upstream)
  ) else $error("primary master bit set while not mastering upstream");

  a_pmst_enable: assert property (
    !perr_resp_pri && !primary_master_err ##1 !perr_resp_pri |-> !primary_master_err
  ) else $error("primary master bit set with response disabled");

  a_pmst_trigger: assert property (
    master_pri && perr_resp_pri && txn_upstream && is_txn && perr_det_pri
      |=> primary_master_err
  ) else $error("primary master bit missed an upstream error");

  a_smst_master: assert property (
    $rose(secondary_master_err) |-> $past(master_sec) && !$past(txn_upstream)
  ) else $error("secondary master bit set while not mastering downstream");

  a_smst_enable: assert property (
    $rose(secondary_master_err) |-> $past(perr_resp_sec)
  ) else $error("secondary master bit set with response disabled");

  a_smst_pin: assert property (
    master_sec && perr_resp_sec && !txn_upstream && is_txn && pin_evt_sec
      |=> secondary_master_err
  ) else $error("secondary master bit missed a target error pin");

  a_smst_cause: assert property (
    $rose(secondary_master_err) |-> $past(pin_evt_sec || perr_det_sec)
  ) else $error("secondary master bit rose without a cause");

  a_bctl_read: assert property (
    s_bctl_read |=> s_axi_rvalid && (s_axi_rdata[BPS_BIT_SPERR_RESP] == $past(perr_resp_sec))
  ) else $error("bridge control read lost the secondary enable");

  a_sticky_hold: assert property (
    $fell(primary_det_err) |-> $past(wr_pcmd && w_strb[3] && w_data[BPS_BIT_DPE])
  ) else $error("primary detected bit dropped without a clear write");

  a_write_resp: assert property (
    aw_held && w_held && !s_axi_bvalid |=> s_axi_bvalid
  ) else $error("write response not raised one cycle after both halves");

endmodule

`default_nettype wire

// File: bps_agent.sv
// far-side bus agent: drives transaction context and the target error pins
`timescale 1ns/1ps
`default_nettype none

module bps_agent (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              go,
  input  wire bps_pkg::bps_txn_t c_type,
  input  wire logic              c_up,
  input  wire logic              c_sec,
  input  wire logic              c_pin,
  input  wire logic              c_mpri,
  input  wire logic              c_msec,
  output logic                   busy,
  output bps_pkg::bps_txn_t      txn_type,
  output logic                   txn_upstream,
  output logic                   master_pri,
  output logic                   master_sec,
  output logic                   perr_det_pri,
  output logic                   perr_det_sec,
  output logic                   primary_parity_err_n,
  output logic                   secondary_parity_err_n
);
  import bps_pkg::*;

  logic [3:0] cnt;

  assign busy = (cnt != 4'h0);

  // ----------------------------------------------------------------
  // one transaction: context held 12 cycles, pin low for the first 4
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt                    <= 4'h0;
      txn_type               <= BPS_TXN_NONE;
      txn_upstream           <= 1'b0;
      master_pri             <= 1'b0;
      master_sec             <= 1'b0;
      perr_det_pri           <= 1'b0;
      perr_det_sec           <= 1'b0;
      primary_parity_err_n   <= 1'b1;
      secondary_parity_err_n <= 1'b1;
    end else if (go && !busy) begin
      cnt                    <= 4'hc;
      txn_type               <= c_type;
      txn_upstream           <= c_up;
      master_pri             <= c_mpri;
      master_sec             <= c_msec;
      perr_det_pri           <= !c_pin && !c_sec;
      perr_det_sec           <= !c_pin && c_sec;
      primary_parity_err_n   <= !(c_pin && !c_sec);
      secondary_parity_err_n <= !(c_pin && c_sec);
    end else if (busy) begin
      cnt          <= cnt - 4'h1;
      perr_det_pri <= 1'b0;
      perr_det_sec <= 1'b0;
      // pins are pulled up once the target lets go
      if (cnt == 4'h9) begin
        primary_parity_err_n   <= 1'b1;
        secondary_parity_err_n <= 1'b1;
      end
      if (cnt == 4'h1) begin
        txn_type <= BPS_TXN_NONE;
      end
    end else begin
      // context means nothing between transactions, so keep it moving
      txn_upstream <= !txn_upstream;
      master_pri   <= !master_pri;
      master_sec   <= master_pri;
    end
  end
endmodule

`default_nettype wire

// File: bps_tb.sv
// self-checking bench for the bridge parity status block
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); \
  end \
end

module tb;
  import bps_pkg::*;

  logic              clk_sys, rst, go, c_up, c_sec, c_pin, c_mpri, c_msec, busy;
  bps_txn_t          c_type, txn_type;
  logic              txn_upstream, master_pri, master_sec, perr_det_pri, perr_det_sec;
  logic              pri_n, sec_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, en_p, en_s;
  logic              dpri, mpri, dsec, msec;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb, e;
  logic [1:0]        bresp, rresp, be;
  logic [33:0]       re;
  logic [1:0]        wq[$];
  logic [33:0]       rq[$];
  int                miscompares, check_count;

  bps_parity_status DUT (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .txn_type(txn_type), .txn_upstream(txn_upstream), .master_pri(master_pri),
    .master_sec(master_sec), .perr_det_pri(perr_det_pri), .perr_det_sec(perr_det_sec),
    .primary_parity_err_n(pri_n), .secondary_parity_err_n(sec_n),
    .perr_resp_pri(en_p), .perr_resp_sec(en_s), .primary_det_err(dpri),
    .primary_master_err(mpri), .secondary_det_err(dsec), .secondary_master_err(msec));

  bps_agent u_agent (.clk_sys(clk_sys), .rst(rst), .go(go), .c_type(c_type), .c_up(c_up),
    .c_sec(c_sec), .c_pin(c_pin), .c_mpri(c_mpri), .c_msec(c_msec), .busy(busy),
    .txn_type(txn_type), .txn_upstream(txn_upstream), .master_pri(master_pri),
    .master_sec(master_sec), .perr_det_pri(perr_det_pri), .perr_det_sec(perr_det_sec),
    .primary_parity_err_n(pri_n), .secondary_parity_err_n(sec_n));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic bail();
    miscompares++;
    $display("unexpected at %0t: wait ran out", $time);
    conclude();
  endtask

  // ----------------------------------------------------------------
  // register bus master and result monitor
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] r);
    int  n;
    bit  a_ok, w_ok;
    @(posedge clk_sys);
    wq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    a_ok = 0;
    w_ok = 0;
    while (!(a_ok && w_ok) && n < 50) begin
      @(posedge clk_sys);
      n++;
      if (!a_ok && awready) begin a_ok = 1; awvalid <= 1'b0; end
      if (!w_ok && wready) begin w_ok = 1; wvalid <= 1'b0; end
    end
    while (n < 50 && !bvalid) begin @(posedge clk_sys); n++; end
    bready <= 1'b0;
    if (n >= 50) bail();
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] x);
    int n;
    @(posedge clk_sys);
    rq.push_back(x);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (!arready && n < 50);
    arvalid <= 1'b0;
    do begin @(posedge clk_sys); n++; end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50) bail();
  endtask

  always @(posedge clk_sys) begin
    if (bvalid && bready) begin
      be = (wq.size() > 0) ? wq.pop_front() : 2'h1;
      `CHK(bresp, be)
    end
    if (rvalid && rready) begin
      re = (rq.size() > 0) ? rq.pop_front() : 34'h1;
      `CHK({rresp, rdata}, re)
    end
  end

  task automatic fire(input bps_txn_t t, input logic up, sec, pin, mp, ms);
    int n;
    @(posedge clk_sys);
    c_type <= t;
    {c_up, c_sec, c_pin, c_mpri, c_msec} <= {up, sec, pin, mp, ms};
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (busy && n < 40);
    if (n >= 40) bail();
  endtask

  function automatic logic [31:0] word(logic d, logic m, logic en, int pos);
    return (32'(d) << BPS_BIT_DPE) | (32'(m) << BPS_BIT_MDPE) | (32'(en) << pos);
  endfunction

  function automatic logic [3:0] expect_sts(bps_txn_t t, logic up, sec, pin, mp, ms, ep, es);
    logic rd, wr;
    logic [3:0] x;
    rd = (t == BPS_TXN_READ);
    wr = (t == BPS_TXN_POSTED) || (t == BPS_TXN_DELAYED);
    x[BPS_STS_PDET] = !pin && !sec && ((rd && up) || (wr && !up));
    x[BPS_STS_SDET] = !pin && sec && ((rd && !up) || (wr && up));
    x[BPS_STS_PMST] = !sec && up && mp && ep && (rd || wr);
    x[BPS_STS_SMST] = sec && !up && ms && es && (rd || wr);
    return x;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic up, sec, pin, mp, ms, ep, es;
    bps_txn_t t;
    {rst, go, c_up, c_sec, c_pin, c_mpri, c_msec} = 7'h40;
    c_type = BPS_TXN_NONE;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    miscompares = 0;
    check_count = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    void'($urandom(32'h9c30a0dd));
    for (int i = 0; i < 64; i++) begin
      t = bps_txn_t'(i % 4);
      {up, sec} = 2'(i / 4);
      {pin, mp, ms, ep, es} = 5'($urandom());
      axi_wr(BPS_OFF_PCMD, word(1'b0, 1'b0, ep, BPS_BIT_PERR_RESP), 4'h1, BPS_RESP_OK);
      axi_wr(BPS_OFF_BCTL, word(1'b0, 1'b0, es, BPS_BIT_SPERR_RESP), 4'h4, BPS_RESP_OK);
      fire(t, up, sec, pin, mp, ms);
      e = expect_sts(t, up, sec, pin, mp, ms, ep, es);
      `CHK({en_s, en_p}, {es, ep})
      `CHK({msec, dsec, mpri, dpri}, e)
      axi_rd(BPS_OFF_PCMD, {BPS_RESP_OK, word(e[0], e[1], ep, BPS_BIT_PERR_RESP)});
      axi_rd(BPS_OFF_SSTAT, {BPS_RESP_OK, word(e[2], e[3], 1'b0, 0)});
      axi_rd(BPS_OFF_BCTL, {BPS_RESP_OK, word(1'b0, 1'b0, es, BPS_BIT_SPERR_RESP)});
      axi_wr(BPS_OFF_PCMD, 32'hffffffff, 4'h8, BPS_RESP_OK);
      axi_wr(BPS_OFF_SSTAT, 32'hffffffff, 4'h8, BPS_RESP_OK);
      `CHK({msec, dsec, mpri, dpri, en_p}, {4'h0, ep})
    end
    $display("test sweep finished");
    axi_rd(8'h80, {BPS_RESP_ERR, 32'h0});
    axi_wr(8'h80, 32'hffffffff, 4'hf, BPS_RESP_ERR);
    $display("test unmapped finished");
    axi_wr(BPS_OFF_PCMD, 32'h40, 4'h1, BPS_RESP_OK);
    fire(BPS_TXN_READ, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    `CHK({mpri, dpri}, 2'h3)
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    `CHK({msec, dsec, mpri, dpri, en_s, en_p}, 6'h0)
    axi_rd(BPS_OFF_PCMD, {BPS_RESP_OK, 32'h0});
    $display("test reset finished");
    conclude();
  end
endmodule

`default_nettype wire
